// ### hdl/pdh_test_frame_mapper.sv
`timescale 1ns/10ps
`include "pdh_frame_cfg.svh"

module fifo_buf #(
  parameter int WIDTH = `FIFO_WIDTH,
  parameter int DEPTH = `FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // filling side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // draining side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_reg;
  logic [AW-1:0] rdPtr_reg;
  logic [AW:0] count_reg;
  wire wrFire = inValid && inReady;
  wire rdFire = outValid && outReady;

  assign inReady = count_reg != DEPTH[AW:0];
  assign outValid = count_reg != '0;
  assign outData = mem[rdPtr_reg];

  always_ff @(posedge clk) begin
    if (wrFire) begin
      mem[wrPtr_reg] <= inData;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (wrFire) begin
        wrPtr_reg <= wrPtr_reg + 1'b1;
      end
      if (rdFire) begin
        rdPtr_reg <= rdPtr_reg + 1'b1;
      end
      count_reg <= count_reg + {{AW{1'b0}}, wrFire} - {{AW{1'b0}}, rdFire};
    end
  end
endmodule

// Contract
// - 44M frame: seven 680-bit subframes, 4760 bits
// - eight sets: one overhead bit, 84 test
// - 56 overhead bits: lead, F, C order
// - multiframe alignment bits in subframes 5-7: 010
// - subframe sync bits a to d are 1001
// - channel n stuffs in subframe n
// - stuffing: all three C bits one
// - no stuffing: all three C bits zero
// - stuff bit n is nth after F4
// - 97M frame: six 192-bit sets, three overhead
// - 97M alignment 110 set one, 001 set four
// - sets 2,3,5 carry per-tributary control bits
// - set six: prior parity, national, remote alarm
// - 97M opportunity n: nth slot after aux bits
// - 139M frame: six 488-bit sets
// - set one: alignment, alarm, three national bits
// - sets two-five open with four control bits
// - set six: control bits, then opportunity bits
module pdh_test_frame_mapper (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // test sequence in
  input wire logic seqBit,
  input wire logic seqValid,
  output logic seqReady,
  // user settings, asynchronous levels
  input wire logic [1:0] modeSel,
  input wire logic [6:0] stuffReq,
  input wire logic [1:0] alarmSel,
  input wire logic [1:0] paritySel,
  input wire logic [2:0] nationalSel,
  input wire logic remoteAlarm,
  // line out
  output logic lineBit,
  output logic lineValid,
  output logic frameStart,
  output logic overheadFlag
);
  localparam int SW = 17;
  logic [SW-1:0] setMeta_reg;
  logic [SW-1:0] setSync_reg;
  pdh_frame_pkg::mode_t modeCur_reg;
  logic [6:0] stuffLat_reg;
  logic [8:0] bitInSet_reg;
  logic [5:0] setIdx_reg;
  logic parAcc_reg;
  logic parPrev_reg;
  logic lineBit_reg;
  logic lineValid_reg;
  logic frameStart_reg;
  logic overhead_reg;
  logic fifoValid;
  logic fifoBit;
  logic seqReady_reg;
  logic fifoInReady;

  // settings pass two flops before use
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      setMeta_reg <= '0;
      setSync_reg <= '0;
    end else begin
      setMeta_reg <= {modeSel, stuffReq, alarmSel, paritySel, nationalSel, remoteAlarm};
      setSync_reg <= setMeta_reg;
    end
  end

  wire [1:0] sMode = setSync_reg[16:15];
  wire [6:0] sStuff = setSync_reg[14:8];
  wire [1:0] sAlarm = setSync_reg[7:6];
  wire [1:0] sParity = setSync_reg[5:4];
  wire [2:0] sNational = setSync_reg[3:1];
  wire sRemAlarm = setSync_reg[0];

  wire is44 = modeCur_reg == pdh_frame_pkg::MODE_44;
  wire is97 = modeCur_reg == pdh_frame_pkg::MODE_97;
  wire [2:0] sub = setIdx_reg[5:3];
  wire [2:0] sis = setIdx_reg[2:0];
  wire [8:0] subPlus = {6'h00, sub} + 9'h001;

  // 44M subframe overhead
  wire [6:0] leadVec = {`MFAS_44, sParity, sAlarm};
  wire lead44 = leadVec[sub];
  wire [3:0] sfas = `SFAS_44;
  wire fBit44 = sfas[2'h3 - sis[2:1]];
  wire oh44 = bitInSet_reg == 9'h000;
  wire val44 = (sis == 3'h0) ? lead44 : (sis[0] ? fBit44 : stuffLat_reg[sub]);
  wire stuff44 = (sis == `JUST_LAST_SET_44) && (bitInSet_reg == subPlus)
                 && stuffLat_reg[sub];

  // 97M overhead
  wire [1:0] b97 = bitInSet_reg[1:0];
  wire [2:0] fas1 = `FAS1_97;
  wire [2:0] fas2 = `FAS2_97;
  wire [2:0] aux97 = {parPrev_reg, sNational[0], sRemAlarm};
  wire oh97 = bitInSet_reg < `OH_LEN_97;
  wire val97 = (sis == 3'h0) ? fas1[2'h2 - b97] :
               (sis == `FAS2_SET_97) ? fas2[2'h2 - b97] :
               (sis == `JUST_SET) ? aux97[2'h2 - b97] : stuffLat_reg[b97];
  wire [8:0] slot97 = bitInSet_reg - `OH_LEN_97;
  wire stuff97 = (sis == `JUST_SET) && !oh97 && (slot97 < `OH_LEN_97)
                 && stuffLat_reg[slot97[1:0]];

  // 139M overhead
  wire [15:0] word139 = {`FAS_139, sRemAlarm, sNational};
  wire oh139 = (sis == 3'h0) ? (bitInSet_reg < `OH_LEN_139_FIRST)
                             : (bitInSet_reg < `OH_LEN_139);
  wire val139 = (sis == 3'h0) ? word139[4'hf - bitInSet_reg[3:0]]
                              : stuffLat_reg[bitInSet_reg[1:0]];
  wire stuff139 = (sis == `JUST_SET) && !oh139 && (bitInSet_reg < 9'h008)
                  && stuffLat_reg[bitInSet_reg[1:0]];

  // selection by mode
  wire isOh = is44 ? oh44 : (is97 ? oh97 : oh139);
  wire ohBit = is44 ? val44 : (is97 ? val97 : val139);
  wire isStuff = is44 ? stuff44 : (is97 ? stuff97 : stuff139);
  wire needSeq = !isOh && !isStuff;
  wire advance = !needSeq || fifoValid;
  wire rdFire = needSeq && fifoValid;
  wire outBit = isOh ? ohBit : (isStuff ? `STUFF_FILL : fifoBit);
  wire [8:0] setLen = is44 ? `SET_LEN_44 : (is97 ? `SET_LEN_97 : `SET_LEN_139);
  wire [5:0] numSets = is44 ? `SETS_44 : (is97 ? `SETS_97 : `SETS_139);
  wire lastBit = bitInSet_reg == setLen - 9'h001;
  wire frameEnd = lastBit && (setIdx_reg == numSets - 6'h01);
  wire frameWrap = advance && frameEnd;

  pdh_frame_pkg::mode_t modeNext;
  assign modeNext = (sMode == 2'h1) ? pdh_frame_pkg::MODE_97 :
                    (sMode == 2'h2) ? pdh_frame_pkg::MODE_139 : pdh_frame_pkg::MODE_44;

  // stream buffer; not drained in overhead or stuff slots, stalls the source only when full
  fifo_buf #(.WIDTH(`FIFO_WIDTH), .DEPTH(`FIFO_DEPTH)) u_buf (
    .clk(clk),
    .resetn(resetn),
    .inValid(seqValid),
    .inReady(fifoInReady),
    .inData(seqBit),
    .outValid(fifoValid),
    .outReady(needSeq),
    .outData(fifoBit)
  );

  // frame position; holds while a test bit is owed but none is buffered
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bitInSet_reg <= '0;
      setIdx_reg <= '0;
    end else if (advance) begin
      bitInSet_reg <= lastBit ? 9'h000 : bitInSet_reg + 9'h001;
      if (lastBit) begin
        setIdx_reg <= frameEnd ? 6'h00 : setIdx_reg + 6'h01;
      end
    end
  end

  // mode and stuffing change only on frame boundaries
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      modeCur_reg <= pdh_frame_pkg::MODE_44;
      stuffLat_reg <= `STUFF_RST;
    end else if (frameWrap) begin
      modeCur_reg <= modeNext;
      stuffLat_reg <= sStuff;
    end
  end

  // parity over all bits of the frame just sent
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      parAcc_reg <= `PARITY_RST;
      parPrev_reg <= `PARITY_RST;
    end else if (advance) begin
      parAcc_reg <= frameEnd ? `PARITY_RST : parAcc_reg ^ outBit;
      if (frameEnd) begin
        parPrev_reg <= parAcc_reg ^ outBit;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lineBit_reg <= 1'b0;
      lineValid_reg <= 1'b0;
      frameStart_reg <= 1'b0;
      overhead_reg <= 1'b0;
      seqReady_reg <= 1'b0;
    end else begin
      lineBit_reg <= advance ? outBit : 1'b0;
      lineValid_reg <= advance;
      frameStart_reg <= advance && (bitInSet_reg == 9'h000) && (setIdx_reg == 6'h00);
      overhead_reg <= advance && isOh;
      seqReady_reg <= fifoInReady;
    end
  end

  // registered copy is a hint; the fifo accepts only when it has room
  assign seqReady = seqReady_reg;
  assign lineBit = lineBit_reg;
  assign lineValid = lineValid_reg;
  assign frameStart = frameStart_reg;
  assign overheadFlag = overhead_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence wrapSeq;
    frameWrap && is44;
  endsequence
  sequence restartSeq;
    (bitInSet_reg == 9'h000) && (setIdx_reg == 6'h00);
  endsequence
  // overhead slots never stall, so the alignment word leaves back to back
  sequence fas139Seq;
    lineBit_reg [*5] ##1 !lineBit_reg ##1 lineBit_reg ##1 (!lineBit_reg) [*5];
  endsequence
  // a stuff slot leaves as fill and is not flagged as overhead
  sequence stuffOutSeq;
    lineValid_reg && !overhead_reg && !lineBit_reg;
  endsequence

  frame_len_a: assert property (
    wrapSeq |-> setIdx_reg == 6'h37 && bitInSet_reg == 9'h054 ##1 restartSeq)
    else $error("44M frame length wrong");
  oh_pos_a: assert property (is44 && bitInSet_reg == 9'h055 |-> 1'b0)
    else $error("44M set longer than 85");
  mfas_a: assert property (
    advance && is44 && oh44 && sis == 3'h0 && sub >= 3'h4 |=> lineBit_reg == (sub == 3'h5))
    else $error("multiframe alignment bit wrong");
  sfas_a: assert property (
    advance && is44 && oh44 && (sis == 3'h1 || sis == 3'h7) |=> lineBit_reg && overhead_reg)
    else $error("outer subframe sync bit not one");
  cbits_a: assert property (
    advance && is44 && oh44 && sis == 3'h4 |=> lineBit_reg == $past(stuffLat_reg[sub]))
    else $error("control bit disagrees with stuffing");
  stuff_pos_a: assert property (
    is44 && isStuff |-> sis == 3'h7 && bitInSet_reg == subPlus && !rdFire ##1 stuffOutSeq)
    else $error("stuff slot misplaced or consumed test bit");
  fas97_a: assert property (
    advance && is97 && sis == 3'h3 && bitInSet_reg == 9'h002 |=> lineBit_reg && $past(isOh))
    else $error("97M second alignment word wrong");
  aux97_a: assert property (
    advance && is97 && sis == 3'h5 && bitInSet_reg == 9'h002
    |=> overhead_reg && lineBit_reg == $past(sRemAlarm))
    else $error("97M remote alarm bit wrong");
  stuff97_a: assert property (
    is97 && isStuff |-> sis == 3'h5 && bitInSet_reg >= 9'h003 && bitInSet_reg < 9'h006
    ##1 stuffOutSeq)
    else $error("97M stuff slot misplaced");
  fas139_a: assert property (
    advance && !is44 && !is97 && bitInSet_reg == 9'h000 && setIdx_reg == 6'h00 |=> fas139Seq)
    else $error("139M alignment word wrong");
  ctl139_a: assert property (
    advance && !is44 && !is97 && sis != 3'h0 && bitInSet_reg < 9'h004
    |=> overhead_reg && lineBit_reg == $past(stuffLat_reg[bitInSet_reg[1:0]]))
    else $error("139M control bit wrong");
  seq_flow_a: assert property (
    rdFire |=> lineValid_reg && !overhead_reg && lineBit_reg == $past(fifoBit))
    else $error("test bit not passed through");
endmodule

// ### hdl/pdh_frame_cfg.svh
`ifndef PDH_FRAME_CFG_SVH
`define PDH_FRAME_CFG_SVH

// set lengths and sets per frame for each rate
`define SET_LEN_44 9'h055
`define SET_LEN_97 9'h0c0
`define SET_LEN_139 9'h1e8
`define SETS_44 6'h38
`define SETS_97 6'h06
`define SETS_139 6'h06

// overhead field widths and positions
`define OH_LEN_97 9'h003
`define OH_LEN_139_FIRST 9'h010
`define OH_LEN_139 9'h004
`define JUST_SET 3'h5
`define JUST_LAST_SET_44 3'h7
`define FAS2_SET_97 3'h3

// alignment patterns and stuff fill value
`define MFAS_44 3'h2
`define SFAS_44 4'h9
`define FAS1_97 3'h6
`define FAS2_97 3'h1
`define FAS_139 12'hfa0
`define STUFF_FILL 1'h0

// reset values
`define STUFF_RST 7'h00
`define PARITY_RST 1'h0

// data buffer
`define FIFO_DEPTH 8
`define FIFO_WIDTH 1

`endif

// ### hdl/pdh_frame_pkg.sv
package pdh_frame_pkg;

  typedef enum logic [2:0] {
    MODE_44 = 3'b001,
    MODE_97 = 3'b010,
    MODE_139 = 3'b100
  } mode_t;

endpackage

// ### verification/line_sink.sv
`timescale 1ns/10ps
module line_sink (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // line from the mapper
  input wire logic lineBit,
  input wire logic lineValid,
  input wire logic frameStart,
  input wire logic overheadFlag
);
  // held cycles carry no bit, so only advancing cycles are kept
  logic capBit[$];
  logic capOh[$];
  logic capFs[$];
  always @(posedge clk) begin
    if (resetn && lineValid) begin
      capBit.push_back(lineBit);
      capOh.push_back(overheadFlag);
      capFs.push_back(frameStart);
    end
  end
endmodule

// ### verification/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic clk = 0, resetn = 0, seqBit = 0, seqValid = 0, remoteAlarm = 0;
  logic feedOn = 0, burst = 0;
  logic [1:0] modeSel = 0, alarmSel = 0, paritySel = 0;
  logic [6:0] stuffReq = 0;
  logic [2:0] nationalSel = 0;
  logic seqReady, lineBit, lineValid, frameStart, overheadFlag;
  int feedIdx = 0, nFail = 0, testsRun = 0;

  pdh_test_frame_mapper dut (.clk, .resetn, .seqBit, .seqValid, .seqReady, .modeSel, .stuffReq,
    .alarmSel, .paritySel, .nationalSel, .remoteAlarm, .lineBit, .lineValid, .frameStart,
    .overheadFlag);
  line_sink line (.clk, .resetn, .lineBit, .lineValid, .frameStart, .overheadFlag);

  initial begin
    forever #5 clk = ~clk;
  end

  function automatic logic pat(int k);
    return ^(k[11:0] & 12'h8a5);
  endfunction

  // {kind, value}: kind 0 test, 1 overhead, 2 stuff, 3 overhead checked against the parity of the frame before
  function automatic logic [2:0] expSlot(int m, int p);
    int s;
    int r;
    int f;
    logic [6:0] lead;
    logic [11:0] fas;
    lead = {3'b010, paritySel, alarmSel};
    fas = 12'hfa0;
    if (m == 0 || m == 3) begin
      f = p / 680;
      s = (p % 680) / 85;
      r = (p % 680) % 85;
      if (r == 0 && s == 0) return {2'd1, lead[f]};
      if (r == 0 && s[0]) return {2'd1, s == 1 || s == 7};
      if (r == 0) return {2'd1, stuffReq[f]};
      if (s == 7 && r == f + 1 && stuffReq[f]) return 3'b100;
      return 3'b000;
    end
    if (m == 1) begin
      s = p / 192;
      r = p % 192;
      if (r < 3 && s == 0) return {2'd1, r < 2};
      if (r < 3 && s == 3) return {2'd1, r == 2};
      if (r == 0 && s == 5) return 3'b110;
      if (r == 1 && s == 5) return {2'd1, nationalSel[0]};
      if (r == 2 && s == 5) return {2'd1, remoteAlarm};
      if (r < 3) return {2'd1, stuffReq[r]};
      if (s == 5 && r < 6 && stuffReq[r - 3]) return 3'b100;
      return 3'b000;
    end
    s = p / 488;
    r = p % 488;
    if (s == 0 && r < 12) return {2'd1, fas[11 - r]};
    if (s == 0 && r == 12) return {2'd1, remoteAlarm};
    if (s == 0 && r < 16) return {2'd1, nationalSel[15 - r]};
    if (s > 0 && r < 4) return {2'd1, stuffReq[r]};
    if (s == 5 && r < 8 && stuffReq[r - 4]) return 3'b100;
    return 3'b000;
  endfunction

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      nFail++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task final_report;
    if (nFail == 0 && testsRun > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // with feedOn, offers a bit only every other cycle: seqReady lags a cycle, so this never overruns; burst offers one every cycle
  always @(posedge clk) begin
    if (seqValid) feedIdx++;
    #1;
    if (burst) begin
      seqValid = 1;
      seqBit = 1;
    end else if (feedOn && !seqValid && seqReady === 1'b1) begin
      seqValid = 1;
      seqBit = pat(feedIdx);
    end else seqValid = 0;
  end

  task rst;
    feedOn <= 0;
    burst <= 0;
    resetn = 0;
    repeat (16) @(posedge clk);
    #1;
    feedIdx = 0;
    line.capBit.delete();
    line.capOh.delete();
    line.capFs.delete();
    resetn = 1;
  endtask

  // first frame is always 44M without stuffing, so the second frame is judged
  task automatic run_frame(int m, int len, logic [6:0] st, logic [1:0] al, logic [1:0] pa,
    logic [2:0] na, logic ra);
    int k;
    logic [2:0] e;
    logic [2:0] seen;
    logic [2:0] want;
    logic par;
    @(posedge clk);
    #1;
    modeSel = m[1:0];
    stuffReq = st;
    alarmSel = al;
    paritySel = pa;
    nationalSel = na;
    remoteAlarm = ra;
    rst();
    feedOn <= 1;
    for (int i = 0; i < 30000 && line.capBit.size() <= 4760 + len; i++) #10;
    feedOn <= 0;
    k = 4704;
    par = 1'b0;
    for (int q = 0; q < 4760; q++) par ^= line.capBit[q];
    check("frame mark", line.capFs[0], 1'b1);
    check("frame length", line.capFs[4760 + len], 1'b1);
    for (int p = 0; p < len; p++) begin
      e = expSlot(m, p);
      seen = {line.capFs[4760 + p], line.capOh[4760 + p], line.capBit[4760 + p]};
      want = {p == 0, e[2:1] == 2'd1 || e[2:1] == 2'd3, e[2:1] == 2'd0 ? pat(k) : e[0]};
      if (e[2:1] == 2'd3) want[0] = par;
      if (e[2:1] == 2'd3) check("aux slot", seen, want);
      else check($sformatf("slot %0d", p), seen, want);
      if (e[2:1] == 2'd0) k++;
    end
  endtask

  task frames_44;
    run_frame(0, 4760, 7'h55, 2'b01, 2'b10, 3'h0, 1'b0);
    run_frame(3, 4760, 7'h2a, 2'b10, 2'b01, 3'h0, 1'b0);
  endtask

  task frame_97;
    run_frame(1, 1152, 7'h05, 2'b00, 2'b00, 3'h1, 1'b1);
  endtask

  task frame_139;
    run_frame(2, 2928, 7'h0a, 2'b00, 2'b00, 3'h6, 1'b0);
  endtask

  task fifo_refuse;
    int bad;
    rst();
    burst <= 1;
    for (int i = 0; i < 1000 && seqReady !== 1'b0; i++) #10;
    check("ready", seqReady, 1'b0);
    burst <= 0;
    repeat (100) #10;
    bad = 0;
    repeat (20) begin
      #10;
      if (lineValid !== 1'b0) bad++;
    end
    check("hold", bad, 0);
  endtask

  initial begin
    frames_44();
    frame_97();
    frame_139();
    fifo_refuse();
    final_report();
  end

  initial begin
    #1_000_000;
    nFail++;
    final_report();
  end
endmodule
